// [txl_mem.sv]
`timescale 1ns/1ps
`default_nettype none

module txl_mem #(
	parameter int            AW         = 6,
	parameter int            DW         = 6,
	parameter int            DEPTH      = 48,
	parameter logic [DW-1:0] RESET_WORD = '0
) (
	input wire logic ref_clk,     // register clock
	input wire logic rst_n,       // synchronous reset, active low
	txl_mem_if.mem   port         // write, software read and lookup read
);

	logic [DW-1:0] words      [DEPTH];
	logic [DW-1:0] next_words [DEPTH];
	logic [DW-1:0] next_rd_data;
	logic [DW-1:0] next_lk_data;

	// per-entry reset keeps every mapping defined without a clearing sequence
	for (genvar i = 0; i < DEPTH; i++) begin : g_word
		always_comb begin
			next_words[i] = words[i];
			if (!rst_n) begin
				next_words[i] = RESET_WORD;
			end else if (port.wr_en && (int'(port.wr_addr) == i)) begin
				next_words[i] = port.wr_data;
			end
		end

		always_ff @(posedge ref_clk) begin
			words[i] <= next_words[i];
		end
	end

	// addresses past the table read as zero rather than aliasing
	always_comb begin
		next_rd_data = '0;
		next_lk_data = '0;
		if (rst_n && (int'(port.rd_addr) < DEPTH)) begin
			next_rd_data = words[port.rd_addr];
		end
		if (rst_n && (int'(port.lk_addr) < DEPTH)) begin
			next_lk_data = words[port.lk_addr];
		end
	end

	always_ff @(posedge ref_clk) begin
		port.rd_data <= next_rd_data;
		port.lk_data <= next_lk_data;
	end

endmodule

`default_nettype wire

// [txl_mem_if.sv]
`timescale 1ns/1ps
`default_nettype none

interface txl_mem_if #(
	parameter int AW = 6,
	parameter int DW = 6
);
	logic          wr_en;
	logic [AW-1:0] wr_addr;
	logic [DW-1:0] wr_data;
	logic [AW-1:0] rd_addr;
	logic [DW-1:0] rd_data;
	logic [AW-1:0] lk_addr;
	logic [DW-1:0] lk_data;

	modport ctrl (
		output wr_en,
		output wr_addr,
		output wr_data,
		output rd_addr,
		output lk_addr,
		input  rd_data,
		input  lk_data
	);

	modport mem (
		input  wr_en,
		input  wr_addr,
		input  wr_data,
		input  rd_addr,
		input  lk_addr,
		output rd_data,
		output lk_data
	);
endinterface

`default_nettype wire

// [txl_pkg.sv]
package txl_pkg;

	localparam int TXL_REG_ADDR_W = 12;
	localparam int TXL_REG_DATA_W = 8;

	localparam logic [TXL_REG_ADDR_W-1:0] TXL_ADDR_SELECT = 12'h41B;
	localparam logic [TXL_REG_ADDR_W-1:0] TXL_ADDR_ENTRY  = 12'h41C;

	localparam logic [TXL_REG_DATA_W-1:0] TXL_SELECT_RESET = 8'h00;
	localparam logic [TXL_REG_DATA_W-1:0] TXL_READ_IDLE    = 8'h00;

	// select register fields
	localparam int TXL_SEL_DIR_BIT = 7;

	localparam int TXL_ATM_ADDR_W = 5;
	localparam int TXL_CHAN_W     = 6;

	// entry register fields (direction one)
	localparam int TXL_ENT_ACTIVE_BIT = 7;

	// channel codes
	localparam logic [TXL_CHAN_W-1:0] TXL_CHAN_BYPASS_LAST = 6'h1F;
	localparam logic [TXL_CHAN_W-1:0] TXL_CHAN_GROUP_FIRST = 6'h20;
	localparam logic [TXL_CHAN_W-1:0] TXL_CHAN_LAST        = 6'h2F;
	localparam logic [TXL_CHAN_W-1:0] TXL_CHAN_UNASSIGNED  = 6'h30;

	// forward table: one channel code per ATM address
	localparam int TXL_FWD_DEPTH = 32;
	localparam int TXL_FWD_W     = TXL_CHAN_W;
	localparam int TXL_FWD_AW    = TXL_ATM_ADDR_W;

	// reverse table: active flag above the ATM address, one per channel code 0x00-0x2F
	localparam int TXL_REV_DEPTH      = 48;
	localparam int TXL_REV_W          = TXL_ATM_ADDR_W + 1;
	localparam int TXL_REV_AW         = TXL_CHAN_W;
	localparam int TXL_REV_ACTIVE_BIT = TXL_ATM_ADDR_W;

	localparam logic [TXL_REV_W-1:0] TXL_REV_RESET = 6'h00;

	typedef enum logic {
		TXL_DIR_ATM_TO_CHAN = 1'b0,
		TXL_DIR_CHAN_TO_ATM = 1'b1
	} txl_dir_type;

endpackage

// [txl_xlate.sv]
// Summary of operation
// - select register picks entry; data register accesses it
// - select bit 7 chooses translation direction
// - direction zero: select bits 4-0 are ATM address
// - direction one: select bits 5-0 are channel
// - channel codes 0x00-0x1F are bypass ports
// - channel codes 0x20-0x2F are IMA groups
// - direction zero: data bits 5-0 hold channel
// - direction zero: 0x30 means address not assigned
// - direction one: data bit 7 is channel active
// - direction one: data bits 4-0 hold ATM address
`timescale 1ns/1ps
`default_nettype none

module txl_xlate
	import txl_pkg::*;
(
	input  wire logic                      ref_clk,            // register clock, 10 MHz
	input  wire logic                      rst_n,              // synchronous reset, active low
	input  wire logic [TXL_REG_ADDR_W-1:0] reg_addr,           // register address
	input  wire logic [TXL_REG_DATA_W-1:0] reg_wr_data,        // register write data
	input  wire logic                      reg_wr,             // write strobe
	input  wire logic                      reg_rd,             // read strobe
	output logic      [TXL_REG_DATA_W-1:0] reg_rd_data,        // read data, cycle after strobe
	input  wire logic [TXL_ATM_ADDR_W-1:0] cell_atm_addr,      // forward lookup key
	output logic      [TXL_CHAN_W-1:0]     cell_chan,          // channel for cell_atm_addr
	output logic                           cell_chan_assigned, // address belongs to this device
	output logic                           cell_chan_is_group, // channel is an IMA group
	input  wire logic [TXL_CHAN_W-1:0]     tx_chan,            // reverse lookup key
	output logic                           tx_chan_active,     // channel marked active
	output logic      [TXL_ATM_ADDR_W-1:0] tx_chan_atm_addr    // ATM address for tx_chan
);

	txl_mem_if #(.AW(TXL_FWD_AW), .DW(TXL_FWD_W)) fwd_if ();
	txl_mem_if #(.AW(TXL_REV_AW), .DW(TXL_REV_W)) rev_if ();

	txl_mem #(
		.AW         (TXL_FWD_AW),
		.DW         (TXL_FWD_W),
		.DEPTH      (TXL_FWD_DEPTH),
		.RESET_WORD (TXL_CHAN_UNASSIGNED)
	) u_fwd_table (
		.ref_clk (ref_clk),
		.rst_n   (rst_n),
		.port    (fwd_if.mem)
	);

	txl_mem #(
		.AW         (TXL_REV_AW),
		.DW         (TXL_REV_W),
		.DEPTH      (TXL_REV_DEPTH),
		.RESET_WORD (TXL_REV_RESET)
	) u_rev_table (
		.ref_clk (ref_clk),
		.rst_n   (rst_n),
		.port    (rev_if.mem)
	);

	// ---------------------------------------------------------------
	// select register and address decode
	// ---------------------------------------------------------------

	logic [TXL_REG_DATA_W-1:0] select;
	logic [TXL_REG_DATA_W-1:0] next_select;
	txl_dir_type               dir;
	logic [TXL_ATM_ADDR_W-1:0] sel_atm_addr;
	logic [TXL_CHAN_W-1:0]     sel_chan;
	logic                      sel_chan_valid;
	logic                      hit_select;
	logic                      hit_entry;
	logic                      wr_entry;

	assign hit_select = (reg_addr == TXL_ADDR_SELECT);
	assign hit_entry  = (reg_addr == TXL_ADDR_ENTRY);
	assign wr_entry   = reg_wr && hit_entry;

	// bit 6 is stored and read back but steers nothing
	always_comb begin
		next_select = select;
		if (!rst_n) begin
			next_select = TXL_SELECT_RESET;
		end else if (reg_wr && hit_select) begin
			next_select = reg_wr_data;
		end
	end

	always_ff @(posedge ref_clk) begin
		select <= next_select;
	end

	assign dir          = txl_dir_type'(select[TXL_SEL_DIR_BIT]);
	assign sel_atm_addr = select[TXL_ATM_ADDR_W-1:0];
	assign sel_chan     = select[TXL_CHAN_W-1:0];

	// codes above the last group have no entry; writes to them are dropped
	assign sel_chan_valid = (sel_chan <= TXL_CHAN_LAST);

	// ---------------------------------------------------------------
	// table writes: only the entry named by the select register changes
	// ---------------------------------------------------------------

	always_comb begin
		fwd_if.wr_en   = wr_entry && (dir == TXL_DIR_ATM_TO_CHAN);
		fwd_if.wr_addr = sel_atm_addr;
		fwd_if.wr_data = reg_wr_data[TXL_CHAN_W-1:0];

		rev_if.wr_en   = wr_entry && (dir == TXL_DIR_CHAN_TO_ATM)
		                 && sel_chan_valid;
		rev_if.wr_addr = sel_chan;
		rev_if.wr_data = {reg_wr_data[TXL_ENT_ACTIVE_BIT],
		                  reg_wr_data[TXL_ATM_ADDR_W-1:0]};
	end

	// ---------------------------------------------------------------
	// software read port of both tables
	// the tables are addressed from the select register at all times, so
	// the word is registered at the edge that ends the cycle of the strobe,
	// and a select write followed at once by an entry read returns the
	// newly selected entry
	// ---------------------------------------------------------------

	always_comb begin
		fwd_if.rd_addr = sel_atm_addr;
		rev_if.rd_addr = sel_chan;
	end

	logic        rd_select;
	logic        rd_entry;
	logic        next_rd_select;
	logic        next_rd_entry;
	txl_dir_type rd_dir;
	txl_dir_type next_rd_dir;

	logic [TXL_REG_DATA_W-1:0] rd_data;
	logic [TXL_REG_DATA_W-1:0] next_rd_data;

	always_comb begin
		next_rd_select = 1'b0;
		next_rd_entry  = 1'b0;
		next_rd_dir    = TXL_DIR_ATM_TO_CHAN;
		next_rd_data   = TXL_READ_IDLE;
		if (rst_n && reg_rd) begin
			next_rd_select = hit_select;
			next_rd_entry  = hit_entry;
			next_rd_dir    = dir;
			if (hit_select) begin
				next_rd_data = select;
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		rd_select <= next_rd_select;
		rd_entry  <= next_rd_entry;
		rd_dir    <= next_rd_dir;
		rd_data   <= next_rd_data;
	end

	// entry data come straight from the table's output flops; unmapped
	// addresses and out-of-range channels read as zero
	always_comb begin
		reg_rd_data = TXL_READ_IDLE;
		if (rd_select) begin
			reg_rd_data = rd_data;
		end else if (rd_entry) begin
			if (rd_dir == TXL_DIR_ATM_TO_CHAN) begin
				reg_rd_data = {{(TXL_REG_DATA_W-TXL_CHAN_W){1'b0}},
				               fwd_if.rd_data};
			end else begin
				reg_rd_data = {rev_if.rd_data[TXL_REV_ACTIVE_BIT],
				               {(TXL_REG_DATA_W-TXL_REV_W){1'b0}},
				               rev_if.rd_data[TXL_ATM_ADDR_W-1:0]};
			end
		end
	end

	// ---------------------------------------------------------------
	// datapath lookups, one cycle of latency each
	// ---------------------------------------------------------------

	always_comb begin
		fwd_if.lk_addr = cell_atm_addr;
		rev_if.lk_addr = tx_chan;
	end

	assign cell_chan        = fwd_if.lk_data;
	assign tx_chan_active   = rev_if.lk_data[TXL_REV_ACTIVE_BIT];
	assign tx_chan_atm_addr = rev_if.lk_data[TXL_ATM_ADDR_W-1:0];

	// anything outside the channel ranges, 0x30 among them, is not ours
	assign cell_chan_assigned = (fwd_if.lk_data <= TXL_CHAN_LAST);
	assign cell_chan_is_group = (fwd_if.lk_data >= TXL_CHAN_GROUP_FIRST)
	                            && (fwd_if.lk_data <= TXL_CHAN_LAST);

endmodule

`default_nettype wire

// [txl_xlate_properties.sv]
`timescale 1ns/1ps
`default_nettype none
module txl_xlate_properties
	import txl_pkg::*;
(
	input wire logic        ref_clk,            // clock
	input wire logic        rst_n,              // reset
	input wire logic [11:0] reg_addr,           // address
	input wire logic [7:0]  reg_wr_data,        // write data
	input wire logic        reg_wr,             // write strobe
	input wire logic        reg_rd,             // read strobe
	input wire logic [7:0]  reg_rd_data,        // read data
	input wire logic [4:0]  cell_atm_addr,      // forward key
	input wire logic [5:0]  cell_chan,          // forward result
	input wire logic        cell_chan_assigned, // assigned flag
	input wire logic        cell_chan_is_group, // group flag
	input wire logic [5:0]  tx_chan,            // reverse key
	input wire logic        tx_chan_active,     // active flag
	input wire logic [4:0]  tx_chan_atm_addr    // reverse result
);
	logic [7:0] sel;
	logic [7:0] next_sel;
	wire ws = reg_wr && reg_addr == TXL_ADDR_SELECT;
	wire we = reg_wr && reg_addr == TXL_ADDR_ENTRY;
	wire rs = reg_rd && reg_addr == TXL_ADDR_SELECT;
	wire re = reg_rd && reg_addr == TXL_ADDR_ENTRY;
	wire wf = we && !sel[7];
	wire wr = we && sel[7] && sel[5:0] <= TXL_CHAN_LAST;
	// shadow of the select register, rebuilt from bus traffic
	always_comb begin
		next_sel = sel;
		if (!rst_n)
			next_sel = TXL_SELECT_RESET;
		else if (ws)
			next_sel = reg_wr_data;
	end
	always_ff @(posedge ref_clk) sel <= next_sel;
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	rd_idle_a: assert property (!$past(reg_rd && rst_n) |-> reg_rd_data == 8'h00)
		else $error("read data not idle");
	unmap_rd_a: assert property (reg_rd && !rs && !re |=> reg_rd_data == 8'h00)
		else $error("unmapped read not zero");
	sel_back_a: assert property (ws ##1 rs |=> reg_rd_data == $past(reg_wr_data, 2))
		else $error("select readback wrong");
	fwd_back_a: assert property (wf ##1 re |=>
		reg_rd_data == {2'b00, $past(reg_wr_data[5:0], 2)}) else $error("forward readback wrong");
	rev_back_a: assert property (wr ##1 re |=> reg_rd_data ==
		{$past(reg_wr_data[7], 2), 2'b00, $past(reg_wr_data[4:0], 2)}) else $error("reverse readback");
	fwd_look_a: assert property (wf ##1 cell_atm_addr == $past(sel[4:0]) |=>
		cell_chan == $past(reg_wr_data[5:0], 2)) else $error("forward lookup wrong");
	rev_look_a: assert property (wr ##1 tx_chan == $past(sel[5:0]) |=>
		{tx_chan_active, tx_chan_atm_addr} == $past({reg_wr_data[7], reg_wr_data[4:0]}, 2))
		else $error("reverse lookup wrong");
	rev_none_a: assert property (tx_chan > TXL_CHAN_LAST |=>
		!tx_chan_active && tx_chan_atm_addr == 5'h00) else $error("code above range not zero");
	assigned_flag_a: assert property ($past(rst_n) |->
		cell_chan_assigned == (cell_chan <= TXL_CHAN_LAST)) else $error("assigned flag wrong");
	group_flag_a: assert property (cell_chan_is_group ==
		(cell_chan >= TXL_CHAN_GROUP_FIRST && cell_chan <= TXL_CHAN_LAST)) else $error("group flag");
	// ties the flag to a programmed code, not to the design's own compare
	unassigned_look_a: assert property (wf && reg_wr_data[5:0] == TXL_CHAN_UNASSIGNED ##1
		cell_atm_addr == $past(sel[4:0]) |=> !cell_chan_assigned && !cell_chan_is_group)
		else $error("unassigned address flagged as ours");
endmodule
bind txl_xlate txl_xlate_properties u_txl_xlate_properties (.ref_clk(ref_clk), .rst_n(rst_n),
	.reg_addr(reg_addr), .reg_wr_data(reg_wr_data), .reg_wr(reg_wr), .reg_rd(reg_rd),
	.reg_rd_data(reg_rd_data), .cell_atm_addr(cell_atm_addr), .cell_chan(cell_chan),
	.cell_chan_assigned(cell_chan_assigned), .cell_chan_is_group(cell_chan_is_group),
	.tx_chan(tx_chan), .tx_chan_active(tx_chan_active), .tx_chan_atm_addr(tx_chan_atm_addr));
`default_nettype wire

// [txl_xlate_tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module txl_xlate_tb_top;
	import txl_pkg::*;
	logic        ref_clk = 1'b0;
	logic        rst_n = 1'b0;
	logic [11:0] reg_addr = 12'h000;
	logic [7:0]  reg_wr_data = 8'h00;
	logic        reg_wr = 1'b0;
	logic        reg_rd = 1'b0;
	logic [4:0]  cell_atm_addr = 5'h00;
	logic [5:0]  tx_chan = 6'h00;
	logic [7:0]  reg_rd_data, sel, er;
	logic [5:0]  cell_chan, ec, et;
	logic        cell_chan_assigned, cell_chan_is_group, tx_chan_active;
	logic [4:0]  tx_chan_atm_addr;
	logic [5:0]  fwd [32];
	logic [5:0]  rev [48];
	logic [31:0] k;
	int          n_errors = 0, checks = 0, cycles = 0, i;
	int          seed = 32'h55339F7D;
	txl_xlate u_txl_xlate (.ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr),
		.reg_wr_data(reg_wr_data), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rd_data(reg_rd_data),
		.cell_atm_addr(cell_atm_addr), .cell_chan(cell_chan),
		.cell_chan_assigned(cell_chan_assigned), .cell_chan_is_group(cell_chan_is_group),
		.tx_chan(tx_chan), .tx_chan_active(tx_chan_active), .tx_chan_atm_addr(tx_chan_atm_addr));
	always #50 ref_clk = ~ref_clk;
	task automatic stop_test();
		$display("errors %0d checks %0d", n_errors, checks);
		if (n_errors == 0 && checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic chk_rd(input logic [7:0] e, input logic [7:0] g);
		checks++;
		if (g !== e) begin
			n_errors++;
			$display("ERROR reg_rd_data expected %h seen %h", e, g);
		end
	endtask
	task automatic chk_lk(input string n, input logic [5:0] e, input logic [5:0] g);
		checks++;
		if (g !== e) begin
			n_errors++;
			$display("ERROR %s expected %h seen %h", n, e, g);
		end
	endtask
	// a hang in the loop below would otherwise run forever
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 3000) begin
			n_errors++;
			stop_test();
		end
	end
	initial begin
		for (i = 0; i < 32; i++) fwd[i] = TXL_CHAN_UNASSIGNED;
		for (i = 0; i < 48; i++) rev[i] = 6'h00;
		sel = TXL_SELECT_RESET;
		repeat (20) @(posedge ref_clk);
		rst_n <= 1'b1;
		for (i = 0; i < 2000; i++) begin
			@(posedge ref_clk);
			// model sees the cycle just ended; a write lands after this edge's lookup
			ec = fwd[cell_atm_addr];
			et = (tx_chan <= TXL_CHAN_LAST) ? rev[tx_chan] : 6'h00;
			er = 8'h00;
			if (reg_rd && reg_addr == TXL_ADDR_SELECT) er = sel;
			if (reg_rd && reg_addr == TXL_ADDR_ENTRY && !sel[7]) er = {2'b00, fwd[sel[4:0]]};
			if (reg_rd && reg_addr == TXL_ADDR_ENTRY && sel[7] && sel[5:0] <= TXL_CHAN_LAST)
				er = {rev[sel[5:0]][5], 2'b00, rev[sel[5:0]][4:0]};
			if (reg_wr && reg_addr == TXL_ADDR_SELECT) sel = reg_wr_data;
			if (reg_wr && reg_addr == TXL_ADDR_ENTRY && !sel[7]) fwd[sel[4:0]] = reg_wr_data[5:0];
			if (reg_wr && reg_addr == TXL_ADDR_ENTRY && sel[7] && sel[5:0] <= TXL_CHAN_LAST)
				rev[sel[5:0]] = {reg_wr_data[7], reg_wr_data[4:0]};
			k = $random(seed);
			reg_wr <= k[1:0] == 2'd1;
			reg_rd <= k[1:0] == 2'd2;
			reg_addr <= (k[3:2] == 2'd0) ? k[31:20] : (k[2] ? TXL_ADDR_ENTRY : TXL_ADDR_SELECT);
			reg_wr_data <= k[11:4];
			// keys often follow the selected entry so fresh writes get looked up
			cell_atm_addr <= k[12] ? sel[4:0] : k[17:13];
			tx_chan <= k[18] ? sel[5:0] : k[24:19];
			@(negedge ref_clk);
			chk_rd(er, reg_rd_data);
			chk_lk("cell_chan", ec, cell_chan);
			chk_lk("assigned", {5'h00, ec <= TXL_CHAN_LAST}, {5'h00, cell_chan_assigned});
			chk_lk("group", {5'h00, ec >= TXL_CHAN_GROUP_FIRST && ec <= TXL_CHAN_LAST},
				{5'h00, cell_chan_is_group});
			chk_lk("tx_chan", et, {tx_chan_active, tx_chan_atm_addr});
		end
		stop_test();
	end
endmodule
`default_nettype wire
